// ---- core/lcdtg_pkg.sv ----
// Package: constants, field layout and types for the LCD panel timing generator
package lcdtg_pkg;

    localparam int DIV_LSB       = 12;
    localparam int DIV_W         = 9;
    localparam int LCNT_LSB      = 21;
    localparam int LCNT_W        = 11;

    localparam int VFP_LSB       = 0;
    localparam int VBP_LSB       = 8;
    localparam int VPW_LSB       = 16;
    localparam int VHD_LSB       = 24;
    localparam int VFLD_W        = 8;
    localparam int VPW_W         = 6;

    localparam int HBP_LSB       = 0;
    localparam int HPW_LSB       = 8;
    localparam int HFP_LSB       = 21;
    localparam int HBP_W         = 8;
    localparam int HPW_W         = 8;
    localparam int HFP_W         = 11;

    localparam int HOZ_LSB       = 21;
    localparam int HOZ_W         = 11;
    localparam int LINE_LSB      = 0;
    localparam int LINE_W        = 11;

    localparam int BURST_LSB     = 24;
    localparam int BURST_W       = 7;
    localparam int FSIZE_LSB     = 0;
    localparam int FSIZE_W       = 24;
    localparam int WORD_BITS     = 32;

    localparam int LINE_EXTRA    = 4;
    localparam int FRAME_EXTRA   = 1;
    localparam int CNT_W         = 16;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Second control register bit positions
    localparam int C2_MATRIX     = 0;
    localparam int C2_IFW_LSB    = 1;
    localparam int C2_COLOUR     = 3;
    localparam int C2_SCAN       = 4;
    localparam int C2_BPP_LSB    = 5;
    localparam int C2_INV_FRM    = 8;
    localparam int C2_INV_LINE   = 9;
    localparam int C2_INV_CLK    = 10;
    localparam int C2_DOT_CLOCK_RUN_MODE     = 15;
    localparam int C2_ORDER      = 31;

    typedef enum logic [2:0] {
        LCDTG_DELAY  = 3'b000,
        LCDTG_HPULSE = 3'b001,
        LCDTG_BPORCH = 3'b011,
        LCDTG_ACTIVE = 3'b010,
        LCDTG_FPORCH = 3'b110,
        LCDTG_PAD    = 3'b111
    } lcdtg_phase_type;

    typedef struct packed {
        logic pixel_dot_clock;
        logic line_sync_out;
        logic frame_sync_out;
        logic frame_pulse_out;
        logic data_enable;
    } lcdtg_pins_type;

    typedef struct packed {
        logic        dma_start;
        logic [6:0]  burst;
        logic [23:0] words;
    } lcdtg_dma_type;

endpackage : lcdtg_pkg

// ---- core/lcdtg_core.sv ----
// LCD panel timing generator: dot clock, line and frame sync, line counter
`timescale 1ns/10ps
module lcdtg_core
    import lcdtg_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           nrst,
    input  wire logic           ce,
    input  wire logic           enable,
    input  wire logic [31:0]    display_control_one,
    input  wire logic [31:0]    display_control_two,
    input  wire logic [31:0]    vertical_timing_reg,
    input  wire logic [31:0]    horizontal_timing_reg,
    input  wire logic [31:0]    frame_geometry_reg,
    input  wire logic [31:0]    dma_frame_size_reg,
    output logic      [31:0]    display_control_one_rd,
    output logic      [15:0]    active_dots,
    output lcdtg_pins_type      pins,
    output lcdtg_dma_type       dma
);

    // Configuration decode
    logic [DIV_W-1:0]  dot_clock_divider;
    logic [VFLD_W-1:0] vertical_front_porch;
    logic [VFLD_W-1:0] vertical_back_porch;
    logic [VPW_W-1:0]  vsync_pulse_width;
    logic [VFLD_W-1:0] vsync_to_hsync_delay;
    logic [HBP_W-1:0]  horizontal_back_porch;
    logic [HPW_W-1:0]  hsync_pulse_width;
    logic [HFP_W-1:0]  horizontal_front_porch;
    logic [HOZ_W-1:0]  active_width_field;
    logic [LINE_W-1:0] active_line_count_field;
    logic              passive_mode;
    logic              one_panel_scan;
    logic              passive_colour_select;
    logic              eight_line_interface;
    logic              frame_sync_polarity;
    logic              line_inv;
    logic              clk_inv;
    logic              dot_clock_run_mode;

    assign dot_clock_divider       = display_control_one[DIV_LSB +: DIV_W];
    assign vertical_front_porch    = vertical_timing_reg[VFP_LSB +: VFLD_W];
    assign vertical_back_porch     = vertical_timing_reg[VBP_LSB +: VFLD_W];
    assign vsync_pulse_width       = vertical_timing_reg[VPW_LSB +: VPW_W];
    assign vsync_to_hsync_delay    = vertical_timing_reg[VHD_LSB +: VFLD_W];
    assign horizontal_back_porch   = horizontal_timing_reg[HBP_LSB +: HBP_W];
    assign hsync_pulse_width       = horizontal_timing_reg[HPW_LSB +: HPW_W];
    assign horizontal_front_porch  = horizontal_timing_reg[HFP_LSB +: HFP_W];
    assign active_width_field      = frame_geometry_reg[HOZ_LSB +: HOZ_W];
    assign active_line_count_field = frame_geometry_reg[LINE_LSB +: LINE_W];
    assign passive_mode            = ~display_control_two[C2_MATRIX];
    assign eight_line_interface    = display_control_two[C2_IFW_LSB];
    assign passive_colour_select   = display_control_two[C2_COLOUR];
    assign one_panel_scan          = ~display_control_two[C2_SCAN];
    assign frame_sync_polarity     = display_control_two[C2_INV_FRM];
    assign line_inv                = display_control_two[C2_INV_LINE];
    assign clk_inv                 = display_control_two[C2_INV_CLK];
    assign dot_clock_run_mode      = display_control_two[C2_DOT_CLOCK_RUN_MODE];

    // Dot clocks of data per line; passive count follows the programmed field as
    // software scales it for data lines and colour.
    assign active_dots = CNT_W'(active_width_field) + CNT_W'(1);
    // Expected data lines, computed only for the unused_ok tie-off and reported on no port
    logic [4:0] data_lines;
    always_comb begin
        data_lines = eight_line_interface ? 5'h08 : 5'h04;
        if (passive_mode && !one_panel_scan) begin
            data_lines = data_lines >> 1;
        end
    end

    // Dot clock divider: one tick every divider+1 master clocks
    logic [DIV_W-1:0] div_q, div_d;
    logic             dot_q, dot_d;
    logic             tick;
    assign tick = (div_q == dot_clock_divider);

    always_comb begin
        div_d = tick ? '0 : div_q + DIV_W'(1);
        dot_d = dot_q;
        if (div_q == (dot_clock_divider >> 1)) begin
            dot_d = 1'b1;
        end
        if (tick) begin
            dot_d = 1'b0;
        end
        if (!enable) begin
            div_d = '0;
            dot_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_q <= '0;
            dot_q <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
            dot_q <= dot_d;
        end
    end

    // Horizontal phase machine
    lcdtg_phase_type   ph_q, ph_d;
    logic [CNT_W-1:0]  hcnt_q, hcnt_d;
    logic [CNT_W-1:0]  ph_len;
    logic              line_end;

    always_comb begin
        case (ph_q)
            LCDTG_DELAY:  ph_len = CNT_W'(vsync_to_hsync_delay);
            LCDTG_HPULSE: ph_len = CNT_W'(hsync_pulse_width);
            LCDTG_BPORCH: ph_len = CNT_W'(horizontal_back_porch);
            LCDTG_ACTIVE: ph_len = CNT_W'(active_width_field);
            LCDTG_FPORCH: ph_len = CNT_W'(horizontal_front_porch) - CNT_W'(1);
            LCDTG_PAD:    ph_len = '0;
            default:      ph_len = '0;
        endcase
    end

    // Four phases take field+1 dots and the front porch takes field dots, so a line
    // is the field sum plus four; a zero front porch is skipped outright.
    assign line_end = tick && (hcnt_q >= ph_len)
                    && ((ph_q == LCDTG_FPORCH)
                       || ((ph_q == LCDTG_ACTIVE) && (horizontal_front_porch == '0)));

    always_comb begin
        ph_d   = ph_q;
        hcnt_d = hcnt_q;
        if (tick) begin
            if (hcnt_q >= ph_len) begin
                hcnt_d = '0;
                case (ph_q)
                    LCDTG_DELAY:  ph_d = LCDTG_HPULSE;
                    LCDTG_HPULSE: ph_d = LCDTG_BPORCH;
                    LCDTG_BPORCH: ph_d = LCDTG_ACTIVE;
                    LCDTG_ACTIVE: begin
                        ph_d = (horizontal_front_porch == '0) ? LCDTG_DELAY
                                                              : LCDTG_FPORCH;
                    end
                    LCDTG_FPORCH: ph_d = LCDTG_DELAY;
                    LCDTG_PAD:    ph_d = LCDTG_DELAY;
                    default:      ph_d = LCDTG_DELAY;
                endcase
            end else begin
                hcnt_d = hcnt_q + CNT_W'(1);
            end
        end
        if (!enable) begin
            ph_d   = LCDTG_DELAY;
            hcnt_d = '0;
        end
    end

    // Pad phase is never entered; it only falls back to the delay phase

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ph_q   <= LCDTG_DELAY;
            hcnt_q <= '0;
        end else if (ce) begin
            ph_q   <= ph_d;
            hcnt_q <= hcnt_d;
        end
    end

    // Vertical line counting
    logic [CNT_W-1:0] vcnt_q, vcnt_d;
    logic [CNT_W-1:0] frame_lines;
    assign frame_lines = CNT_W'(vertical_back_porch) + CNT_W'(active_line_count_field)
                       + CNT_W'(vertical_front_porch) + CNT_W'(FRAME_EXTRA);

    always_comb begin
        vcnt_d = vcnt_q;
        if (line_end) begin
            vcnt_d = (vcnt_q >= frame_lines - CNT_W'(1)) ? '0 : vcnt_q + CNT_W'(1);
        end
        if (!enable) begin
            vcnt_d = '0;
        end
    end

    // Output pins, registered
    lcdtg_pins_type pins_q, pins_d;
    logic           hs_raw, vs_raw, de_raw, vact;
    assign hs_raw = (ph_q == LCDTG_HPULSE);
    assign vs_raw = (vcnt_q <= CNT_W'(vsync_pulse_width));
    // Back porch lines, then line count+1 active lines, the rest is front porch
    assign vact   = (vcnt_q >= CNT_W'(vertical_back_porch))
                 && (vcnt_q <= CNT_W'(vertical_back_porch) + CNT_W'(active_line_count_field));
    assign de_raw = (ph_q == LCDTG_ACTIVE) && vact;

    always_comb begin
        pins_d.pixel_dot_clock = enable && (dot_q ^ clk_inv) &&
                                 (dot_clock_run_mode || de_raw);
        pins_d.line_sync_out   = enable && (hs_raw ^ line_inv);
        pins_d.frame_sync_out  = enable && (vs_raw ^ frame_sync_polarity);
        pins_d.frame_pulse_out = enable && ((vcnt_q == '0) ^ frame_sync_polarity);
        pins_d.data_enable     = enable && de_raw;
    end

    // Line counter: reload at frame start, count down on hsync falling edge
    logic [LCNT_W-1:0] lcnt_q, lcnt_d;
    logic              hs_prev_q, hs_prev_d;
    always_comb begin
        hs_prev_d = hs_raw;
        lcnt_d    = lcnt_q;
        if (hs_prev_q && !hs_raw) begin
            lcnt_d = (vcnt_q == '0) ? active_line_count_field : lcnt_q - LCNT_W'(1);
        end
        if (!enable) begin
            lcnt_d = active_line_count_field;
        end
    end

    // DMA frame request at each frame start
    lcdtg_dma_type dma_d;
    always_comb begin
        dma_d.dma_start = enable && line_end && (vcnt_q >= frame_lines - CNT_W'(1));
        dma_d.burst     = dma_frame_size_reg[BURST_LSB +: BURST_W];
        dma_d.words     = dma_frame_size_reg[FSIZE_LSB +: FSIZE_W];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            vcnt_q    <= '0;
            pins_q    <= '0;
            lcnt_q    <= '0;
            hs_prev_q <= 1'b0;
            dma       <= '0;
        end else if (ce) begin
            vcnt_q    <= vcnt_d;
            pins_q    <= pins_d;
            lcnt_q    <= lcnt_d;
            hs_prev_q <= hs_prev_d;
            dma       <= dma_d;
        end
    end

    assign pins = pins_q;

    // Counter overlays the read path; written bits are ignored there
    always_comb begin
        display_control_one_rd = display_control_one;
        display_control_one_rd[LCNT_LSB +: LCNT_W] = lcnt_q;
    end

    logic unused_ok;
    assign unused_ok = ^{data_lines, passive_colour_select, display_control_two[C2_ORDER],
                         display_control_two[C2_BPP_LSB +: 3]};

endmodule : lcdtg_core

// ---- test/lcdtg_core_properties.sv ----
// Checker: port relations of the LCD timing core
`timescale 1ns/10ps
module lcdtg_core_properties
    import lcdtg_pkg::*;
(
    input wire logic           clk,
    input wire logic           nrst,
    input wire logic           ce,
    input wire logic           enable,
    input wire logic [31:0]    display_control_one,
    input wire logic [31:0]    display_control_two,
    input wire logic [31:0]    frame_geometry_reg,
    input wire logic [31:0]    dma_frame_size_reg,
    input wire logic [31:0]    display_control_one_rd,
    input wire logic [15:0]    active_dots,
    input wire lcdtg_pins_type pins,
    input wire lcdtg_dma_type  dma
);
    logic       dck_q;
    logic       seen_q;
    logic [9:0] gap_q;
    logic       sync_act;
    logic       dck_rise;
    assign sync_act = pins.line_sync_out ^ display_control_two[C2_INV_LINE];
    assign dck_rise = pins.pixel_dot_clock && !dck_q;
    // Gap restarts whenever timing is idle or frozen, so neither a divider change
    // nor a clock-enable pause misfires
    always_ff @(posedge clk) begin
        dck_q <= pins.pixel_dot_clock;
        if (!nrst || !enable || !ce) begin
            seen_q <= 1'b0;
            gap_q  <= 10'h000;
        end else if (dck_rise) begin
            seen_q <= 1'b1;
            gap_q  <= 10'h001;
        end else begin
            gap_q <= gap_q + 10'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_width_plus_one: assert property (active_dots == 16'(frame_geometry_reg[31:21]) + 16'h0001)
        else $error("active_dots is not width field plus one");
    a_rd_low_pass: assert property (display_control_one_rd[20:0] == display_control_one[20:0])
        else $error("control one read path altered low bits");
    a_words_copy: assert property ($past(nrst) && $past(ce) |-> dma.words == $past(dma_frame_size_reg[23:0]))
        else $error("dma words not a copy of input");
    a_burst_copy: assert property ($past(nrst) && $past(ce) |-> dma.burst == $past(dma_frame_size_reg[30:24]))
        else $error("dma burst not a copy of input");
    a_start_single: assert property (dma.dma_start |=> !dma.dma_start)
        else $error("dma start longer than one cycle");
    a_idle_pins_low: assert property ($past(nrst) && !$past(enable) |-> pins == '0)
        else $error("pins not low while idle");
    a_no_data_sync: assert property (enable && $past(enable) && $stable(display_control_two) |-> !(pins.data_enable && sync_act))
        else $error("data enable during line sync");
    a_count_at_fall: assert property (enable && $past(enable) && $changed(display_control_one_rd[31:21]) |-> ##[0:2] !sync_act)
        else $error("line counter moved away from sync fall");
    a_dot_period: assert property (enable && display_control_two[C2_DOT_CLOCK_RUN_MODE] && seen_q && dck_rise |-> gap_q == 10'(display_control_one[20:12]) + 10'h001)
        else $error("dot clock period not divider plus one");
    c_frame_wrap: cover property (dma.dma_start);
    c_line_sync: cover property ($rose(sync_act));
    c_dot_free: cover property (display_control_two[C2_DOT_CLOCK_RUN_MODE] && seen_q && dck_rise);
endmodule : lcdtg_core_properties

bind lcdtg_core lcdtg_core_properties lcdtg_core_properties_inst (
    .clk(clk), .nrst(nrst), .ce(ce), .enable(enable),
    .display_control_one(display_control_one), .display_control_two(display_control_two),
    .frame_geometry_reg(frame_geometry_reg), .dma_frame_size_reg(dma_frame_size_reg),
    .display_control_one_rd(display_control_one_rd), .active_dots(active_dots),
    .pins(pins), .dma(dma)
);

// ---- test/lcdtg_panel_model.sv ----
// Panel model: measures line, frame and data spans seen on the pins
`timescale 1ns/10ps
module lcdtg_panel_model
    import lcdtg_pkg::*;
(
    input  wire logic           clk,
    input  wire lcdtg_pins_type pins,
    input  wire logic           inv_line,
    output logic [15:0]         line_len,
    output logic [15:0]         frame_lines,
    output logic [15:0]         de_len
);
    logic        ls_q;
    logic        fs_q;
    logic        de_q;
    logic [15:0] lc_q;
    logic [15:0] fl_q;
    logic [15:0] dc_q;
    logic        ls_rise;
    assign ls_rise = (pins.line_sync_out ^ inv_line) && !ls_q;
    always_ff @(posedge clk) begin
        ls_q <= pins.line_sync_out ^ inv_line;
        fs_q <= pins.frame_sync_out;
        de_q <= pins.data_enable;
        lc_q <= ls_rise ? 16'h0001 : lc_q + 16'h0001;
        dc_q <= pins.data_enable ? dc_q + 16'h0001 : 16'h0000;
        if (ls_rise)
            line_len <= lc_q;
        if (de_q && !pins.data_enable)
            de_len <= dc_q;
        if (pins.frame_sync_out && !fs_q) begin
            frame_lines <= fl_q;
            fl_q        <= ls_rise ? 16'h0001 : 16'h0000;
        end else if (ls_rise) begin
            fl_q <= fl_q + 16'h0001;
        end
    end
endmodule : lcdtg_panel_model

// ---- test/lcdtg_core_test.sv ----
// Testbench: line, frame, counter and idle behaviour of the timing core
`timescale 1ns/10ps
module lcdtg_core_test;
    import lcdtg_pkg::*;
    logic clk, nrst, ce, enable;
    logic [31:0] c1, c2, vt, ht, fg, dfs, rd;
    logic [15:0] adots, line_len, frame_lines, de_len;
    lcdtg_pins_type pins;
    lcdtg_dma_type  dma;
    int err_count = 0;
    int checks = 0;
    lcdtg_core lcdtg_core_inst (
        .clk(clk), .nrst(nrst), .ce(ce), .enable(enable),
        .display_control_one(c1), .display_control_two(c2),
        .vertical_timing_reg(vt), .horizontal_timing_reg(ht),
        .frame_geometry_reg(fg), .dma_frame_size_reg(dfs),
        .display_control_one_rd(rd), .active_dots(adots), .pins(pins), .dma(dma));
    lcdtg_panel_model lcdtg_panel_model_inst (
        .clk(clk), .pins(pins), .inv_line(c2[C2_INV_LINE]),
        .line_len(line_len), .frame_lines(frame_lines), .de_len(de_len));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Fields change only while idle; ticks per line are 1+2+3+7+4 plus 4
    task automatic configure(input int div, input logic [31:0] ctl2);
        @(posedge clk) enable <= 1'b0;
        repeat (3) @(posedge clk);
        c1 <= 32'hFFE0_0000 | (div << 12);
        c2 <= ctl2;
        @(posedge clk) enable <= 1'b1;
        repeat (4 * 6 * 21 * (div + 1) + 40) @(posedge clk);
        @(negedge clk);
    endtask : configure
    task automatic t_timing(input int div);
        configure(div, 32'h0000_8001);
        check("line_len", 32'(line_len), 21 * (div + 1));
        check("frame_lines", 32'(frame_lines), 6);
        check("de_len", 32'(de_len), 8 * (div + 1));
        check("active_dots", 32'(adots), 8);
    endtask : t_timing
    task automatic t_counter();
        logic [10:0] s [3];
        @(posedge dma.dma_start);
        for (int i = 0; i < 3; i++) begin
            @(negedge pins.line_sync_out);
            repeat (3) @(negedge clk);
            s[i] = rd[31:21];
        end
        check("count step1", 32'(s[1]), 32'(s[0] - 11'h001));
        check("count step2", 32'(s[2]), 32'(s[0] - 11'h002));
        check("rd low", 32'(rd[20:0]), 32'(c1[20:0]));
        check("dma words", 32'(dma.words), 32'h0000_012C);
        check("dma burst", 32'(dma.burst), 32'h0000_0007);
    endtask : t_counter
    task automatic t_invert();
        configure(2, 32'h0000_8201);
        check("line_len inv", 32'(line_len), 63);
        @(posedge pins.data_enable);
        @(negedge clk);
        check("line idle inv", 32'(pins.line_sync_out), 1);
    endtask : t_invert
    // Freeze mid-line with the free-running dot clock: nothing may move
    task automatic t_freeze();
        lcdtg_pins_type held;
        @(posedge pins.data_enable);
        @(posedge clk) ce <= 1'b0;
        @(negedge clk);
        held = pins;
        repeat (12) @(negedge clk);
        check("frozen pins", 32'(pins), 32'(held));
        @(posedge clk) ce <= 1'b1;
    endtask : t_freeze
    task automatic t_idle();
        @(posedge clk) enable <= 1'b0;
        c2 <= 32'h0000_8701;
        repeat (3) @(negedge clk);
        check("idle pins", 32'(pins), 0);
    endtask : t_idle
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        enable = 1'b0;
        c1 = 32'h0000_2000;
        c2 = 32'h0000_8001;
        vt = 32'h0101_0101;
        ht = 32'h0080_0203;
        fg = 32'h00E0_0003;
        dfs = 32'h0700_012C;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_timing(2);
        t_counter();
        t_timing(1);
        t_freeze();
        t_invert();
        t_idle();
        give_verdict();
    end
endmodule : lcdtg_core_test
